// File: hdl/pwmc_pkg.sv
/*
  Constants shared by the three-channel pulse-width modulator block:
  register indices and byte addresses, field positions, reset values
  and the period of each modulator.
  Assumes a 32-bit APB with one aligned word per 8-bit register.
*/
package pwmc_pkg;

  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int unsigned PWMC_NCH     = 3;    // Channels two to four
  localparam int unsigned PWMC_DUTY_W  = 8;    // Duty and counter width
  localparam int unsigned PWMC_PERIOD  = 256;  // Working cycles a period
  localparam int unsigned PWMC_REG_W   = 8;    // Stored register width

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [31:0] PWMC_IDX_DUTY2  = 32'h01FF80C4; // Two, duty
  localparam logic [31:0] PWMC_IDX_SEL2   = 32'h01FF80C5; // Two, sel/div
  localparam logic [31:0] PWMC_IDX_DUTY3  = 32'h01FF80C6; // Three, duty
  localparam logic [31:0] PWMC_IDX_SEL3   = 32'h01FF80C7; // Three, sel/div
  localparam logic [31:0] PWMC_IDX_DUTY4  = 32'h01FF80C8; // Four, duty
  localparam logic [31:0] PWMC_IDX_SEL4   = 32'h01FF80C9; // Four, sel/div
  localparam logic [31:0] PWMC_IDX_ROUTE  = 32'h01FF80CA; // Pin routing
  localparam logic [31:0] PWMC_IDX_STAT   = 32'h01FF80CB; // Output levels

  localparam logic [31:0] PWMC_ADDR_DUTY2 = PWMC_IDX_DUTY2 << 2;
  localparam logic [31:0] PWMC_ADDR_SEL2  = PWMC_IDX_SEL2  << 2;
  localparam logic [31:0] PWMC_ADDR_DUTY3 = PWMC_IDX_DUTY3 << 2;
  localparam logic [31:0] PWMC_ADDR_SEL3  = PWMC_IDX_SEL3  << 2;
  localparam logic [31:0] PWMC_ADDR_DUTY4 = PWMC_IDX_DUTY4 << 2;
  localparam logic [31:0] PWMC_ADDR_SEL4  = PWMC_IDX_SEL4  << 2;
  localparam logic [31:0] PWMC_ADDR_ROUTE = PWMC_IDX_ROUTE << 2;
  localparam logic [31:0] PWMC_ADDR_STAT  = PWMC_IDX_STAT  << 2;

  // ==========================================================
  // Decoded register slots
  // ==========================================================
  localparam logic [3:0] PWMC_SLOT_DUTY2 = 4'h0;
  localparam logic [3:0] PWMC_SLOT_SEL2  = 4'h1;
  localparam logic [3:0] PWMC_SLOT_DUTY3 = 4'h2;
  localparam logic [3:0] PWMC_SLOT_SEL3  = 4'h3;
  localparam logic [3:0] PWMC_SLOT_DUTY4 = 4'h4;
  localparam logic [3:0] PWMC_SLOT_SEL4  = 4'h5;
  localparam logic [3:0] PWMC_SLOT_ROUTE = 4'h6;
  localparam logic [3:0] PWMC_SLOT_STAT  = 4'h7;
  localparam logic [3:0] PWMC_SLOT_NONE  = 4'hF;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned PWMC_SEL_BIT   = 7;  // Output select, top bit of low byte
  localparam int unsigned PWMC_DIV_BIT   = 0;  // Clock divider, bottom bit of low byte
  localparam int unsigned PWMC_RT_FLASH  = 0;  // Flash pin function bit
  localparam int unsigned PWMC_RT_GP5    = 1;  // Pin five config bit
  localparam int unsigned PWMC_RT_GP10   = 2;  // Pin ten config bit
  localparam int unsigned PWMC_LANE0     = 0;  // Byte strobe of low lane

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0]  PWMC_DUTY_RST  = 8'h00;
  localparam logic [1:0]  PWMC_SELDV_RST = 2'h0;
  localparam logic [2:0]  PWMC_ROUTE_RST = 3'h0;
  localparam logic [31:0] PWMC_ZERO32    = 32'h00000000;

endpackage : pwmc_pkg

// File: hdl/pwmc_channel.sv
/*
  One modulator channel: optional halving of the auxiliary tick, a
  free-running 8-bit counter and a registered compare output.
  Assumes a one-cycle tick per auxiliary clock rising edge, already
  synchronised to pclk.
*/
`timescale 1ns/1ns
module pwmc_channel
  import pwmc_pkg::*;
(
  input  wire logic                   pclk,     // System clock
  input  wire logic                   presetn,  // Async reset, low
  input  wire logic                   aux_tick, // Auxiliary edge pulse
  input  wire logic                   div_two,  // Halve the tick rate
  input  wire logic [PWMC_DUTY_W-1:0] duty,     // High-time setting
  output logic                        pwm_q     // Modulated level
);

  // ==========================================================
  // Working clock
  // ==========================================================
  logic                   half_q;  // Toggles on every auxiliary tick
  logic                   step;    // One working-clock cycle
  logic [PWMC_DUTY_W-1:0] cnt_q;   // Position within the period

  // Every tick, or every second tick when halved
  assign step = aux_tick & (~div_two | half_q);

  // Tick phase for the divide-by-two case
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_q <= 1'b0;
    end
    else if (aux_tick)
    begin
      half_q <= ~half_q;  // Phase flips per tick
    end
  end

  // ==========================================================
  // Period counter
  // ==========================================================
  // Eight bits wrap after 256 steps whatever the duty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
    end
    else if (step)
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // Compare
  // ==========================================================
  // High for counts 0..duty: duty+1 of 256 steps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_q <= 1'b0;
    end
    else
    begin
      pwm_q <= (cnt_q <= duty);
    end
  end

endmodule : pwmc_channel

// File: hdl/pwmc_top.sv
/*
  Three pulse-width modulators (channels two, three and four) with an
  APB register slave and the pin routing for the three shared pins.
  Assumes the auxiliary clock is asynchronous and below a quarter of
  pclk, and that chip-select and GPIO sources run on pclk.
*/
// Behaviour
// - Working clock is auxiliary clock over one or two
// - Output period is 256 working cycles
// - High for duty plus one cycles each period
// - Duty is low-byte 8-bit value, 0 to 255
// - Flash select one pin: modulator two, NAND, ordinary
// - Pin five: modulator three, chip select three, GPIO
// - Pin ten: modulator four, modem port, GPIO
// - Reset clears select, divider and duty
`timescale 1ns/1ns
module pwmc_top
  import pwmc_pkg::*;
(
  // APB slave
  input  wire logic        pclk,                // System clock, 25 MHz
  input  wire logic        presetn,             // Async reset, low
  input  wire logic        psel,                // Slave select
  input  wire logic        penable,             // Access phase
  input  wire logic        pwrite,              // Write when high
  input  wire logic [31:0] paddr,               // Byte address
  input  wire logic [31:0] pwdata,              // Write data
  input  wire logic [3:0]  pstrb,               // Byte strobes
  output logic      [31:0] prdata,              // Read data
  output logic             pready,              // Transfer done
  output logic             pslverr,             // Unmapped address
  // Auxiliary clock pin
  input  wire logic        auxiliary_clock,     // Modulator source
  // Alternative sources for the shared pins
  input  wire logic        flash_cs_one_n,      // Ordinary chip select
  input  wire logic        flash_nand_cs_one_n, // NAND-type select
  input  wire logic        chip_sel_three_n,    // Fourth chip select
  input  wire logic        gpio5_do,            // GPIO data, pin five
  input  wire logic        gpio5_oe_n,          // GPIO enable, pin five
  input  wire logic        modem_core_port_b3,  // Modem core signal
  input  wire logic        gpio10_do,           // GPIO data, pin ten
  input  wire logic        gpio10_oe_n,         // GPIO enable, pin ten
  // Shared pins
  output logic             flash_select_one_n,  // Flash select one pin
  output logic             pin_gp5_o,           // Pin five data
  output logic             pin_gp5_oe_n,        // Pin five enable, low
  output logic             pin_gp10_o,          // Pin ten data
  output logic             pin_gp10_oe_n        // Pin ten enable, low
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [PWMC_DUTY_W-1:0] duty_q   [PWMC_NCH]; // Duty bytes
  logic [PWMC_NCH-1:0]    sel_q;               // Output selects
  logic [PWMC_NCH-1:0]    div_q;               // Divider bits
  logic [2:0]             route_q;             // Pin function bits
  logic [PWMC_NCH-1:0]    mod_out;             // Channel outputs
  logic                   aux_s1_q;            // Sync stage one
  logic                   aux_s2_q;            // Sync stage two
  logic                   aux_d_q;             // Delayed for edge
  logic                   aux_tick;            // Rising edge pulse
  logic                   acc;                 // Access phase seen
  logic                   wr_en;               // Write takes effect
  logic [3:0]             slot;                // Decoded register
  logic [31:0]            rd_word;             // Read mux result
  logic                   modulated_out_two;   // Channel two level
  logic                   modulated_out_three; // Channel three level
  logic                   modulated_out_four;  // Channel four level

  // ==========================================================
  // Address decode
  // ==========================================================
  // Maps a byte address to a register slot
  function automatic logic [3:0] pwmc_decode(input logic [31:0] a);
    logic [3:0] s;
    s = PWMC_SLOT_NONE;
    if (a == PWMC_ADDR_DUTY2)
      s = PWMC_SLOT_DUTY2;
    else if (a == PWMC_ADDR_SEL2)
      s = PWMC_SLOT_SEL2;
    else if (a == PWMC_ADDR_DUTY3)
      s = PWMC_SLOT_DUTY3;
    else if (a == PWMC_ADDR_SEL3)
      s = PWMC_SLOT_SEL3;
    else if (a == PWMC_ADDR_DUTY4)
      s = PWMC_SLOT_DUTY4;
    else if (a == PWMC_ADDR_SEL4)
      s = PWMC_SLOT_SEL4;
    else if (a == PWMC_ADDR_ROUTE)
      s = PWMC_SLOT_ROUTE;
    else if (a == PWMC_ADDR_STAT)
      s = PWMC_SLOT_STAT;
    return s;
  endfunction : pwmc_decode

  // Duty slot of a channel
  function automatic logic [3:0] pwmc_duty_slot(input int unsigned ch);
    logic [3:0] s;
    s = PWMC_SLOT_DUTY2 + 4'(2 * ch);
    return s;
  endfunction : pwmc_duty_slot

  // Select and divider slot of a channel
  function automatic logic [3:0] pwmc_sel_slot(input int unsigned ch);
    logic [3:0] s;
    s = PWMC_SLOT_SEL2 + 4'(2 * ch);
    return s;
  endfunction : pwmc_sel_slot

  assign slot  = pwmc_decode(paddr);
  // Access phase, in the one wait state and in the cycle where pready answers
  assign acc   = psel & penable;
  // Write lands only at the edge where pready is seen high
  assign wr_en = acc & pready & pwrite & pstrb[PWMC_LANE0];

  // ==========================================================
  // APB handshake
  // ==========================================================
  // One wait state: pready rises the cycle after access begins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= acc & ~pready;
    end
  end

  // Error flag for unmapped addresses, valid with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= acc & ~pready & (slot == PWMC_SLOT_NONE);
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  // Read mux; bits above the stored byte read as zero
  always_comb
  begin
    rd_word = PWMC_ZERO32;
    for (int unsigned c = 0; c < PWMC_NCH; c++)
    begin
      if (slot == pwmc_duty_slot(c))
      begin
        rd_word[PWMC_DUTY_W-1:0] = duty_q[c];
      end
      if (slot == pwmc_sel_slot(c))
      begin
        rd_word[PWMC_SEL_BIT] = sel_q[c];
        rd_word[PWMC_DIV_BIT] = div_q[c];
      end
    end
    if (slot == PWMC_SLOT_ROUTE)
    begin
      rd_word[2:0] = route_q;
    end
    if (slot == PWMC_SLOT_STAT)
    begin
      rd_word[PWMC_NCH-1:0] = mod_out;
    end
  end

  // Registered read data, loaded with the answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= PWMC_ZERO32;
    end
    else if (acc & ~pready & ~pwrite)
    begin
      prdata <= rd_word;
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < PWMC_NCH; g++)
    begin : g_regs
      // Duty byte, full 0..255 range
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          duty_q[g] <= PWMC_DUTY_RST;
        end
        else if (wr_en && slot == pwmc_duty_slot(g))
        begin
          duty_q[g] <= pwdata[PWMC_DUTY_W-1:0];
        end
      end

      // Output select and divider bits
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          {sel_q[g], div_q[g]} <= PWMC_SELDV_RST;
        end
        else if (wr_en && slot == pwmc_sel_slot(g))
        begin
          sel_q[g] <= pwdata[PWMC_SEL_BIT];
          div_q[g] <= pwdata[PWMC_DIV_BIT];
        end
      end

      // The modulator itself
      pwmc_channel u_chan
      (
        .pclk     (pclk),
        .presetn  (presetn),
        .aux_tick (aux_tick),
        .div_two  (div_q[g]),
        .duty     (duty_q[g]),
        .pwm_q    (mod_out[g])
      );
    end
  endgenerate

  // Pin function bits from the flash and GPIO configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      route_q <= PWMC_ROUTE_RST;
    end
    else if (wr_en && slot == PWMC_SLOT_ROUTE)
    begin
      route_q <= pwdata[2:0];
    end
  end

  assign modulated_out_two   = mod_out[0];
  assign modulated_out_three = mod_out[1];
  assign modulated_out_four  = mod_out[2];

  // ==========================================================
  // Auxiliary clock sampling
  // ==========================================================
  // Two-stage synchroniser, then a rising-edge detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_s1_q <= 1'b0;
      aux_s2_q <= 1'b0;
      aux_d_q  <= 1'b0;
    end
    else
    begin
      aux_s1_q <= auxiliary_clock;
      aux_s2_q <= aux_s1_q;
      aux_d_q  <= aux_s2_q;
    end
  end

  // One pulse per auxiliary rising edge
  assign aux_tick = aux_s2_q & ~aux_d_q;

  // ==========================================================
  // Pin routing
  // ==========================================================
  // Flash select one pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_select_one_n <= 1'b1;  // Deselected
    end
    else if (route_q[PWMC_RT_FLASH] && sel_q[0])
    begin
      flash_select_one_n <= modulated_out_two;
    end
    else if (route_q[PWMC_RT_FLASH])
    begin
      flash_select_one_n <= flash_nand_cs_one_n;
    end
    else
    begin
      flash_select_one_n <= flash_cs_one_n;
    end
  end

  // Pin five: modulator, chip select or GPIO
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_gp5_o    <= 1'b0;
      pin_gp5_oe_n <= 1'b1;  // Released
    end
    else if (route_q[PWMC_RT_GP5] && sel_q[1])
    begin
      pin_gp5_o    <= modulated_out_three;
      pin_gp5_oe_n <= 1'b0;
    end
    else if (route_q[PWMC_RT_GP5])
    begin
      pin_gp5_o    <= chip_sel_three_n;
      pin_gp5_oe_n <= 1'b0;
    end
    else
    begin
      pin_gp5_o    <= gpio5_do;
      pin_gp5_oe_n <= gpio5_oe_n;
    end
  end

  // Pin ten: modulator, modem port or GPIO
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_gp10_o    <= 1'b0;
      pin_gp10_oe_n <= 1'b1;  // Released
    end
    else if (route_q[PWMC_RT_GP10] && sel_q[2])
    begin
      pin_gp10_o    <= modulated_out_four;
      pin_gp10_oe_n <= 1'b0;
    end
    else if (route_q[PWMC_RT_GP10])
    begin
      pin_gp10_o    <= modem_core_port_b3;
      pin_gp10_oe_n <= 1'b0;
    end
    else
    begin
      pin_gp10_o    <= gpio10_do;
      pin_gp10_oe_n <= gpio10_oe_n;
    end
  end

endmodule : pwmc_top

// File: verification/pwmc_properties.sv
/*
  Port-level checker for the three-channel modulator block.
  Assumes it is bound to pwmc_top and that registers change only by APB.
*/
`timescale 1ns/1ns
module pwmc_properties
  import pwmc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_cs_one_n,
  input wire logic        flash_nand_cs_one_n,
  input wire logic        chip_sel_three_n,
  input wire logic        gpio5_do,
  input wire logic        gpio5_oe_n,
  input wire logic        modem_core_port_b3,
  input wire logic        flash_select_one_n,
  input wire logic        pin_gp5_o,
  input wire logic        pin_gp5_oe_n,
  input wire logic        pin_gp10_o
);
  // ==========================================================
  // Shadow of the bits that steer the shared pins
  // ==========================================================
  logic [2:0] rt_q;     // Route bits
  logic [2:0] sl_q;     // Output selects, channels two to four
  logic       wr_hit;   // A write lands at this edge
  logic       fs_cs;    // Flash pin on ordinary select
  logic       fs_nd;    // Flash pin on NAND select
  logic       g5_io;    // Pin five on GPIO
  logic       g5_cs;    // Pin five on chip select
  logic       g10_mp;   // Pin ten on modem port
  assign wr_hit = psel && penable && pready && pwrite && pstrb[0];
  assign fs_cs  = !rt_q[0];
  assign fs_nd  = rt_q[0] && !sl_q[0];
  assign g5_io  = !rt_q[1];
  assign g5_cs  = rt_q[1] && !sl_q[1];
  assign g10_mp = rt_q[2] && !sl_q[2];

  // Follow writes to route and select registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rt_q <= 3'h0;
      sl_q <= 3'h0;
    end
    else if (wr_hit && !pslverr)
    begin
      if (paddr == PWMC_ADDR_ROUTE) rt_q <= pwdata[2:0];
      if (paddr == PWMC_ADDR_SEL2) sl_q[0] <= pwdata[7];
      if (paddr == PWMC_ADDR_SEL3) sl_q[1] <= pwdata[7];
      if (paddr == PWMC_ADDR_SEL4) sl_q[2] <= pwdata[7];
    end

  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  pready_one_wait_a: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready missing one cycle after access start");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  flash_cs_a: assert property ($past(presetn) && $past(fs_cs) |->
    flash_select_one_n == $past(flash_cs_one_n))
    else $error("flash pin not on ordinary select");
  flash_nand_a: assert property ($past(presetn) && $past(fs_nd) |->
    flash_select_one_n == $past(flash_nand_cs_one_n))
    else $error("flash pin not on NAND select");
  gp5_gpio_a: assert property ($past(presetn) && $past(g5_io) |->
    pin_gp5_o == $past(gpio5_do) && pin_gp5_oe_n == $past(gpio5_oe_n))
    else $error("pin five not on GPIO");
  gp5_cs_a: assert property ($past(presetn) && $past(g5_cs) |->
    pin_gp5_o == $past(chip_sel_three_n) && !pin_gp5_oe_n)
    else $error("pin five not on chip select");
  gp10_modem_a: assert property ($past(presetn) && $past(g10_mp) |->
    pin_gp10_o == $past(modem_core_port_b3))
    else $error("pin ten not on modem port");
endmodule : pwmc_properties

bind pwmc_top pwmc_properties u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pready, .pslverr, .flash_cs_one_n, .flash_nand_cs_one_n,
  .chip_sel_three_n, .gpio5_do, .gpio5_oe_n, .modem_core_port_b3,
  .flash_select_one_n, .pin_gp5_o, .pin_gp5_oe_n, .pin_gp10_o
);

// File: verification/pwmc_top_tb_top.sv
/*
  Self-checking bench for the three-channel modulator block.
  Assumes the register map of pwmc_pkg and a one-wait-state APB slave.
*/
`timescale 1ns/1ns
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x); end end
module pwmc_top_tb_top
  import pwmc_pkg::*;
();
  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic [31:0] paddr, pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        aux = 1'b0, fcs_n, fnd_n, cs3_n, g5_do, g5_oe_n, mp_b3;
  logic        g10_do, g10_oe_n, fs_n, g5_o, g5_oen, g10_o, g10_oen;
  logic [7:0]  aux_q = 8'h00;         // Auxiliary clock divider
  int          n_fail    = 0;
  int          tests_run = 0;
  int          hi0, hi1, hi2, per, xp;
  logic [31:0] regs [6] = '{PWMC_ADDR_DUTY2, PWMC_ADDR_SEL2,
    PWMC_ADDR_DUTY3, PWMC_ADDR_SEL3, PWMC_ADDR_DUTY4, PWMC_ADDR_SEL4};
  logic [7:0]  dt_t [5] = '{8'h00, 8'hFF, 8'h7F, 8'h01, 8'hC8};
  logic        dv_t [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  pwmc_top DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .auxiliary_clock(aux),
    .flash_cs_one_n(fcs_n), .flash_nand_cs_one_n(fnd_n),
    .chip_sel_three_n(cs3_n), .gpio5_do(g5_do), .gpio5_oe_n(g5_oe_n),
    .modem_core_port_b3(mp_b3), .gpio10_do(g10_do),
    .gpio10_oe_n(g10_oe_n), .flash_select_one_n(fs_n),
    .pin_gp5_o(g5_o), .pin_gp5_oe_n(g5_oen), .pin_gp10_o(g10_o),
    .pin_gp10_oe_n(g10_oen)
  );

  // System clock, 40 ns
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Auxiliary clock at one eighth of pclk
  always @(posedge pclk)
  begin
    aux_q <= aux_q + 8'h01;
    aux   <= aux_q[2];
  end

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [31:0] a, input logic
    [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) n_fail++;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}, 4'hF);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] x,
    input logic xe);
    apb(1'b0, a, 32'h00000000, 4'h0);
    `CHK(r, x)
    `CHK(e, xe)
  endtask : rd_chk

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    close_out();
  end

  // ==========================================================
  // Test sequence
  // ==========================================================
  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    {fcs_n, fnd_n, cs3_n, g5_do, g5_oe_n, mp_b3, g10_do, g10_oe_n} = 8'hFF;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    foreach (regs[i]) rd_chk(regs[i], 32'h00000000, 1'b0);
    $display("reset values done");
    // Field widths, refused accesses
    foreach (regs[i])
    begin
      wr(regs[i], 8'hFF);
      rd_chk(regs[i], i[0] ? 32'h00000081 : 32'h000000FF, 1'b0);
    end
    apb(1'b1, PWMC_ADDR_DUTY3, 32'h00000055, 4'h0);
    rd_chk(PWMC_ADDR_DUTY3, 32'h000000FF, 1'b0);
    // Duty 255 keeps every channel high all period
    rd_chk(PWMC_ADDR_STAT, 32'h00000007, 1'b0);
    rd_chk(32'h00000100, 32'h00000000, 1'b1);
    $display("registers done");
    // Alternative pin sources: route and select combinations
    for (int k = 0; k < 3; k++)
    begin
      wr(PWMC_ADDR_ROUTE, k[1] ? 8'h07 : 8'h00);
      for (int c = 0; c < 3; c++) wr(regs[2*c+1], k[0] ? 8'h80 : 8'h00);
      for (int p = 0; p < 2; p++)
      begin
        {fcs_n, fnd_n, cs3_n, g5_do, g5_oe_n, mp_b3, g10_do, g10_oe_n}
          <= p[0] ? 8'hA5 : 8'h5A;
        repeat (3) @(posedge pclk);
        `CHK(fs_n, k[1] ? fnd_n : fcs_n)
        `CHK(g5_o, k[1] ? cs3_n : g5_do)
        `CHK(g5_oen, k[1] ? 1'b0 : g5_oe_n)
        `CHK(g10_o, k[1] ? mp_b3 : g10_do)
        `CHK(g10_oen, k[1] ? 1'b0 : g10_oe_n)
      end
    end
    $display("pin routing done");
    // Modulated outputs: high cycles over exactly one period
    wr(PWMC_ADDR_ROUTE, 8'h07);
    rd_chk(PWMC_ADDR_ROUTE, 32'h00000007, 1'b0);
    for (int t = 0; t < 5; t++)
    begin
      for (int c = 0; c < 3; c++)
      begin
        wr(regs[2*c], dt_t[t]);
        wr(regs[2*c+1], {7'h40, dv_t[t]});
      end
      repeat (40) @(posedge pclk);
      {hi0, hi1, hi2} = {32'h0, 32'h0, 32'h0};
      per = 2048 * (dv_t[t] + 1);
      xp = (dt_t[t] + 1) * 8 * (dv_t[t] + 1);
      repeat (per)
      begin
        @(posedge pclk);
        hi0 += fs_n;
        hi1 += g5_o;
        hi2 += g10_o;
      end
      `CHK(hi0, xp)
      `CHK(hi1, xp)
      `CHK(hi2, xp)
      `CHK({g5_oen, g10_oen}, 2'h0)
    end
    $display("modulation done");
    // Reset in mid-run returns registers to reset state and pin ten enable to GPIO
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rd_chk(regs[i], 32'h00000000, 1'b0);
    rd_chk(PWMC_ADDR_ROUTE, 32'h00000000, 1'b0);
    `CHK(g10_oen, g10_oe_n)
    $display("mid-run reset done");
    close_out();
  end
endmodule : pwmc_top_tb_top
